/* File: shared/fua_pkg.sv */
// fua_pkg: constants for the flash unlock key and target address block
// assumes a plain word register port with index offsets
package fua_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0]  REG_KEY          = 4'h0;
    localparam logic [3:0]  REG_ADDR         = 4'h1;
    localparam logic [3:0]  REG_STATUS       = 4'h2;
    localparam logic [31:0] ADDR_RESET       = 32'h00000000;
    localparam logic [31:0] READ_ZERO        = 32'h00000000;
    // ------------------------------------------------------------
    // unlock keys and status fields
    // ------------------------------------------------------------
    // key values are arbitrary
    localparam logic [31:0] KEY_FIRST        = 32'h0000A5A5;
    localparam logic [31:0] KEY_SECOND       = 32'h00005A5A;
    localparam int          STAT_UNLOCK_BIT  = 0;
    localparam int          STAT_ARMED_BIT   = 1;
    localparam int          STAT_ADDRV_BIT   = 2;
    // ------------------------------------------------------------
    // operation select codes and ignored low bits
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        FUA_OP_NOP        = 4'h0,
        FUA_OP_WORD_PROG  = 4'h1,
        FUA_OP_QUAD_PROG  = 4'h2,
        FUA_OP_ROW_PROG   = 4'h3,
        FUA_OP_PAGE_ERASE = 4'h4
    } fua_op_type;
    localparam int          PAGE_LOW_BITS    = 14;
    localparam int          ROW_LOW_BITS     = 11;
    localparam int          QUAD_LOW_BITS    = 4;
    localparam int          WORD_LOW_BITS    = 2;
endpackage : fua_pkg

/* File: core/fua_addr_mask.sv */
// fua_addr_mask: clears ignored low address bits for one granularity
// assumes a combinational use inside the address path
`timescale 1ns/1ps
`default_nettype none
module fua_addr_mask #(
    parameter int LOW_BITS = 2
) (
    input  wire logic [31:0] addr_in,
    output logic      [31:0] addr_out
);
    assign addr_out = {addr_in[31:LOW_BITS], {LOW_BITS{1'b0}}};
endmodule : fua_addr_mask
`default_nettype wire

/* File: core/fua_unlock_seq.sv */
// fua_unlock_seq: two-key unlock sequence tracker
// assumes key writes arrive as one-cycle strobes on clk_in
`timescale 1ns/1ps
`default_nettype none
module fua_unlock_seq (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        key_wr_in,
    input  wire logic [31:0] key_in,
    input  wire logic        other_wr_in,
    input  wire logic        consume_in,
    output logic             armed_out,
    output logic             unlocked_out
);
    logic armed_q;
    logic unlocked_q;

    // ------------------------------------------------------------
    // key pair tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            armed_q    <= 1'b0;
            unlocked_q <= 1'b0;
        end
        else if (key_wr_in)
        begin
            armed_q    <= (key_in == fua_pkg::KEY_FIRST);
            unlocked_q <= armed_q && (key_in == fua_pkg::KEY_SECOND);
        end
        else if (other_wr_in || consume_in)
        begin
            armed_q    <= 1'b0;
            unlocked_q <= 1'b0;
        end
    end

    assign armed_out    = armed_q;
    assign unlocked_out = unlocked_q;
endmodule : fua_unlock_seq
`default_nettype wire

/* File: core/fua_flash_regs.sv */
// fua_flash_regs: flash unlock key and target address registers
// assumes the operation select comes from a separate control register
// and the flash array takes the masked address with a start request
//
// Function
// - key register writable, always reads zero
// - flash change only after unlock sequence
// - target address is 32-bit read/write
// - page erase ignores address bits 13:0
// - row program ignores address bits 10:0
// - word program ignores address bits 1:0
// - quad program ignores address bits 3:0
// - other operations disregard target address
// - address clears only on power-on reset
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fua_flash_regs (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        por_in,
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    input  wire logic [3:0]  flash_operation_select_in,
    input  wire logic        op_start_in,
    output logic             op_go_out,
    output logic      [31:0] op_addr_out,
    output logic             op_addr_valid_out,
    output logic             op_refused_out
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [31:0] flash_target_address_q;
    logic [31:0] rdata_q;
    logic        go_q;
    logic [31:0] op_addr_q;
    logic        addr_valid_q;
    logic        refused_q;
    logic [31:0] page_addr;
    logic [31:0] row_addr;
    logic [31:0] quad_addr;
    logic [31:0] word_addr;
    logic [31:0] sel_addr;
    logic        sel_valid;
    logic        armed;
    logic        unlocked;
    logic        key_wr;
    logic        other_wr;

    assign key_wr   = reg_wr_in && (reg_addr_in == fua_pkg::REG_KEY);
    assign other_wr = reg_wr_in && (reg_addr_in != fua_pkg::REG_KEY);

    // ------------------------------------------------------------
    // unlock sequence
    // ------------------------------------------------------------
    fua_unlock_seq u_unlock (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .key_wr_in    (key_wr),
        .key_in       (reg_wdata_in),
        .other_wr_in  (other_wr),
        .consume_in   (op_start_in),
        .armed_out    (armed),
        .unlocked_out (unlocked)
    );

    // ------------------------------------------------------------
    // target address register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (por_in)
            flash_target_address_q <= fua_pkg::ADDR_RESET;
        else if (reg_wr_in && (reg_addr_in == fua_pkg::REG_ADDR))
            flash_target_address_q <= reg_wdata_in;
    end

    // ------------------------------------------------------------
    // granularity masks
    // ------------------------------------------------------------
    fua_addr_mask #(.LOW_BITS(fua_pkg::PAGE_LOW_BITS)) u_page (
        .addr_in  (flash_target_address_q),
        .addr_out (page_addr)
    );
    fua_addr_mask #(.LOW_BITS(fua_pkg::ROW_LOW_BITS)) u_row (
        .addr_in  (flash_target_address_q),
        .addr_out (row_addr)
    );
    fua_addr_mask #(.LOW_BITS(fua_pkg::QUAD_LOW_BITS)) u_quad (
        .addr_in  (flash_target_address_q),
        .addr_out (quad_addr)
    );
    fua_addr_mask #(.LOW_BITS(fua_pkg::WORD_LOW_BITS)) u_word (
        .addr_in  (flash_target_address_q),
        .addr_out (word_addr)
    );

    // ------------------------------------------------------------
    // operation decode
    // ------------------------------------------------------------
    always_comb
    begin
        sel_addr  = 32'h00000000;
        sel_valid = 1'b0;
        case (flash_operation_select_in)
            fua_pkg::FUA_OP_PAGE_ERASE:
            begin
                sel_addr  = page_addr;
                sel_valid = 1'b1;
            end
            fua_pkg::FUA_OP_ROW_PROG:
            begin
                sel_addr  = row_addr;
                sel_valid = 1'b1;
            end
            fua_pkg::FUA_OP_WORD_PROG:
            begin
                sel_addr  = word_addr;
                sel_valid = 1'b1;
            end
            fua_pkg::FUA_OP_QUAD_PROG:
            begin
                sel_addr  = quad_addr;
                sel_valid = 1'b1;
            end
            default:
            begin
                sel_addr  = 32'h00000000;
                sel_valid = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // operation launch
    // ------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            go_q         <= 1'b0;
            refused_q    <= 1'b0;
            op_addr_q    <= 32'h00000000;
            addr_valid_q <= 1'b0;
        end
        else
        begin
            go_q         <= op_start_in && unlocked;
            refused_q    <= op_start_in && !unlocked;
            op_addr_q    <= sel_addr;
            addr_valid_q <= sel_valid;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            rdata_q <= fua_pkg::READ_ZERO;
        else if (reg_rd_in)
        begin
            case (reg_addr_in)
                fua_pkg::REG_KEY:    rdata_q <= fua_pkg::READ_ZERO;
                fua_pkg::REG_ADDR:   rdata_q <= flash_target_address_q;
                fua_pkg::REG_STATUS:
                begin
                    rdata_q <= fua_pkg::READ_ZERO;
                    rdata_q[fua_pkg::STAT_UNLOCK_BIT] <= unlocked;
                    rdata_q[fua_pkg::STAT_ARMED_BIT]  <= armed;
                    rdata_q[fua_pkg::STAT_ADDRV_BIT]  <= sel_valid;
                end
                default:             rdata_q <= fua_pkg::READ_ZERO;
            endcase
        end
        else
            rdata_q <= fua_pkg::READ_ZERO;
    end

    assign reg_rdata_out     = rdata_q;
    assign op_go_out         = go_q;
    assign op_addr_out       = op_addr_q;
    assign op_addr_valid_out = addr_valid_q;
    assign op_refused_out    = refused_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_key_reads_zero;
        @(posedge clk_in) disable iff (rst_in)
        (reg_rd_in && reg_addr_in == fua_pkg::REG_KEY) |=> (reg_rdata_out == 32'h00000000);
    endproperty
    a_key_reads_zero: assert property (p_key_reads_zero) else $error("key read not zero");

    property p_go_needs_unlock;
        @(posedge clk_in) disable iff (rst_in)
        op_go_out |-> $past(unlocked) && $past(op_start_in);
    endproperty
    a_go_needs_unlock: assert property (p_go_needs_unlock) else $error("go without unlock");

    property p_addr_readback;
        @(posedge clk_in) disable iff (rst_in || por_in)
        (reg_wr_in && reg_addr_in == fua_pkg::REG_ADDR) ##1 (reg_rd_in && reg_addr_in == fua_pkg::REG_ADDR)
            |=> (reg_rdata_out == $past(reg_wdata_in, 2));
    endproperty
    a_addr_readback: assert property (p_addr_readback) else $error("address readback wrong");

    property p_page_mask;
        @(posedge clk_in) disable iff (rst_in)
        (flash_operation_select_in == fua_pkg::FUA_OP_PAGE_ERASE)
            |=> (op_addr_out[13:0] == 14'h0000) && (op_addr_out[31:14] == $past(flash_target_address_q[31:14]));
    endproperty
    a_page_mask: assert property (p_page_mask) else $error("page mask wrong");

    property p_row_mask;
        @(posedge clk_in) disable iff (rst_in)
        (flash_operation_select_in == fua_pkg::FUA_OP_ROW_PROG)
            |=> (op_addr_out[10:0] == 11'h000) && (op_addr_out[31:11] == $past(flash_target_address_q[31:11]));
    endproperty
    a_row_mask: assert property (p_row_mask) else $error("row mask wrong");

    property p_word_mask;
        @(posedge clk_in) disable iff (rst_in)
        (flash_operation_select_in == fua_pkg::FUA_OP_WORD_PROG)
            |=> (op_addr_out[1:0] == 2'h0) && (op_addr_out[31:2] == $past(flash_target_address_q[31:2]));
    endproperty
    a_word_mask: assert property (p_word_mask) else $error("word mask wrong");

    property p_quad_mask;
        @(posedge clk_in) disable iff (rst_in)
        (flash_operation_select_in == fua_pkg::FUA_OP_QUAD_PROG)
            |=> (op_addr_out[3:0] == 4'h0) && (op_addr_out[31:4] == $past(flash_target_address_q[31:4]));
    endproperty
    a_quad_mask: assert property (p_quad_mask) else $error("quad mask wrong");

    property p_other_ignored;
        @(posedge clk_in) disable iff (rst_in)
        !(flash_operation_select_in inside {4'h1, 4'h2, 4'h3, 4'h4})
            |=> !op_addr_valid_out && (op_addr_out == 32'h00000000);
    endproperty
    a_other_ignored: assert property (p_other_ignored) else $error("address used for other op");

    property p_addr_keeps_on_reset;
        @(posedge clk_in)
        (rst_in && !por_in && !reg_wr_in) |=> $stable(flash_target_address_q);
    endproperty
    a_addr_keeps_on_reset: assert property (p_addr_keeps_on_reset) else $error("address lost on reset");

    property p_por_clears;
        @(posedge clk_in)
        por_in |=> (flash_target_address_q == 32'h00000000);
    endproperty
    a_por_clears: assert property (p_por_clears) else $error("por did not clear");

    // ------------------------------------------------------------
    // register port and unlock checks
    // ------------------------------------------------------------
    property p_rdata_idle_zero;
        @(posedge clk_in) disable iff (rst_in)
        !reg_rd_in |=> (reg_rdata_out == fua_pkg::READ_ZERO);
    endproperty
    a_rdata_idle_zero: assert property (p_rdata_idle_zero) else $error("read data not idle zero");

    property p_addr_read_value;
        @(posedge clk_in) disable iff (rst_in)
        (reg_rd_in && reg_addr_in == fua_pkg::REG_ADDR) |=> (reg_rdata_out == $past(flash_target_address_q));
    endproperty
    a_addr_read_value: assert property (p_addr_read_value) else $error("address read value wrong");

    property p_addr_write_lands;
        @(posedge clk_in)
        (reg_wr_in && reg_addr_in == fua_pkg::REG_ADDR && !por_in)
            |=> (flash_target_address_q == $past(reg_wdata_in));
    endproperty
    a_addr_write_lands: assert property (p_addr_write_lands) else $error("address write lost");

    property p_addr_holds;
        @(posedge clk_in)
        (!por_in && !(reg_wr_in && reg_addr_in == fua_pkg::REG_ADDR)) |=> $stable(flash_target_address_q);
    endproperty
    a_addr_holds: assert property (p_addr_holds) else $error("address changed without write");

    property p_refused_no_unlock;
        @(posedge clk_in) disable iff (rst_in)
        (op_start_in && !unlocked) |=> (op_refused_out && !op_go_out);
    endproperty
    a_refused_no_unlock: assert property (p_refused_no_unlock) else $error("locked start not refused");

    property p_go_with_unlock;
        @(posedge clk_in) disable iff (rst_in)
        (op_start_in && unlocked) |=> (op_go_out && !op_refused_out);
    endproperty
    a_go_with_unlock: assert property (p_go_with_unlock) else $error("unlocked start not granted");

    property p_go_single;
        @(posedge clk_in) disable iff (rst_in)
        op_go_out |=> !op_go_out;
    endproperty
    a_go_single: assert property (p_go_single) else $error("grant longer than one cycle");

    property p_unlock_consumed;
        @(posedge clk_in) disable iff (rst_in)
        (op_start_in && !key_wr) |=> !unlocked;
    endproperty
    a_unlock_consumed: assert property (p_unlock_consumed) else $error("unlock survived a start");

    property p_other_write_cancels;
        @(posedge clk_in) disable iff (rst_in)
        other_wr |=> (!armed && !unlocked);
    endproperty
    a_other_write_cancels: assert property (p_other_write_cancels) else $error("write kept unlock");

    property p_armed_needs_first;
        @(posedge clk_in) disable iff (rst_in)
        $rose(armed) |-> ($past(key_wr) && ($past(reg_wdata_in) == fua_pkg::KEY_FIRST));
    endproperty
    a_armed_needs_first: assert property (p_armed_needs_first) else $error("armed without first key");

    property p_unlock_needs_pair;
        @(posedge clk_in) disable iff (rst_in)
        $rose(unlocked) |-> ($past(key_wr) && $past(armed) && ($past(reg_wdata_in) == fua_pkg::KEY_SECOND));
    endproperty
    a_unlock_needs_pair: assert property (p_unlock_needs_pair) else $error("unlock without key pair");

    property p_status_read;
        @(posedge clk_in) disable iff (rst_in)
        (reg_rd_in && reg_addr_in == fua_pkg::REG_STATUS)
            |=> (reg_rdata_out[fua_pkg::STAT_UNLOCK_BIT] == $past(unlocked))
                && (reg_rdata_out[fua_pkg::STAT_ARMED_BIT] == $past(armed));
    endproperty
    a_status_read: assert property (p_status_read) else $error("status bits wrong");

    property p_valid_for_addr_ops;
        @(posedge clk_in) disable iff (rst_in)
        (flash_operation_select_in inside {fua_pkg::FUA_OP_WORD_PROG, fua_pkg::FUA_OP_QUAD_PROG,
            fua_pkg::FUA_OP_ROW_PROG, fua_pkg::FUA_OP_PAGE_ERASE}) |=> op_addr_valid_out;
    endproperty
    a_valid_for_addr_ops: assert property (p_valid_for_addr_ops) else $error("op not marked valid");

    property p_reset_quiets;
        @(posedge clk_in)
        rst_in |=> (!op_go_out && !op_refused_out && !op_addr_valid_out && (op_addr_out == 32'h00000000)
            && (reg_rdata_out == fua_pkg::READ_ZERO));
    endproperty
    a_reset_quiets: assert property (p_reset_quiets) else $error("outputs active after reset");
endmodule : fua_flash_regs
`default_nettype wire

/* File: tb/fua_flash_model.sv */
// fua_flash_model: program flash array stand-in that records granted operations
// assumes op_go_in is a one-cycle pulse and the address beside it is settled
`timescale 1ns/1ps
`default_nettype none
module fua_flash_model (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        op_go_in,
    input  wire logic [31:0] op_addr_in,
    input  wire logic        op_addr_valid_in,
    output logic      [31:0] go_count_out,
    output logic      [31:0] last_addr_out
);
    // --------------------------------------------------------
    // array changes only on a granted start
    // --------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            go_count_out  <= 32'h00000000;
            last_addr_out <= 32'h00000000;
        end
        else if (op_go_in === 1'b1)
        begin
            go_count_out  <= go_count_out + 32'h00000001;
            last_addr_out <= op_addr_valid_in ? op_addr_in : 32'h00000000;
        end
    end
endmodule : fua_flash_model
`default_nettype wire

/* File: tb/tb_fua_flash_regs.sv */
// tb_fua_flash_regs: self-checking bench for the flash key and address registers
// assumes a 40 MHz clock and a register port with read data one cycle later
`timescale 1ns/1ps
`default_nettype none
module tb_fua_flash_regs;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        por_in = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h00000000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [3:0]  op_sel = 4'h0;
    logic        op_start = 1'b0;
    logic        op_go;
    logic [31:0] op_addr;
    logic        op_valid;
    logic        op_refused;
    logic [31:0] go_count;
    logic [31:0] last_addr;
    logic [31:0] m_addr;
    logic [31:0] mask;
    logic [31:0] exp_q[$];
    int          exp_gos = 0;
    int          err_count = 0;
    int          n_tests = 0;

    always #12.5 clk_in = ~clk_in;

    fua_flash_regs i_dut (.clk_in(clk_in), .rst_in(rst_in), .por_in(por_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
        .flash_operation_select_in(op_sel), .op_start_in(op_start), .op_go_out(op_go),
        .op_addr_out(op_addr), .op_addr_valid_out(op_valid), .op_refused_out(op_refused));

    fua_flash_model i_flash (.clk_in(clk_in), .rst_in(rst_in), .op_go_in(op_go), .op_addr_in(op_addr),
        .op_addr_valid_in(op_valid), .go_count_out(go_count), .last_addr_out(last_addr));

    // --------------------------------------------------------
    // checking and bus tasks
    // --------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_in);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_in);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd

    // write, then read back on the very next strobe
    task automatic wr_rd(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_in);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk_in);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, d);
    endtask : wr_rd

    task automatic start(input logic exp_go);
        @(posedge clk_in);
        op_start <= 1'b1;
        @(posedge clk_in);
        op_start <= 1'b0;
        #1 chk({31'h0, op_go}, {31'h0, exp_go});
        chk({31'h0, op_refused}, {31'h0, ~exp_go});
    endtask : start

    task automatic end_of_test;
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial
    begin
        void'($urandom(32'h7565f159));
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0; por_in <= 1'b0;
        rd(fua_pkg::REG_ADDR, fua_pkg::ADDR_RESET);
        for (int i = 0; i < 4; i++)
        begin
            m_addr = $urandom;
            wr_rd(fua_pkg::REG_ADDR, ~m_addr);
            wr(fua_pkg::REG_ADDR, m_addr);
            rd(fua_pkg::REG_ADDR, m_addr);
            wr(fua_pkg::REG_KEY, $urandom);
            rd(fua_pkg::REG_KEY, fua_pkg::READ_ZERO);
        end
        rd(4'hF, 32'h00000000);
        for (int op = 0; op < 16; op++)
        begin
            @(posedge clk_in);
            op_sel <= op[3:0];
            repeat (3) @(posedge clk_in);
            case (op)
                4: mask = 32'hFFFFC000;
                3: mask = 32'hFFFFF800;
                2: mask = 32'hFFFFFFF0;
                1: mask = 32'hFFFFFFFC;
                default: mask = 32'h00000000;
            endcase
            #1 chk({31'h0, op_valid}, {31'h0, mask != 32'h0});
            if (mask != 32'h0)
                chk(op_addr, m_addr & mask);
        end
        @(posedge clk_in);
        op_sel <= fua_pkg::FUA_OP_ROW_PROG;
        start(1'b0);
        wr(fua_pkg::REG_KEY, fua_pkg::KEY_FIRST);
        rd(fua_pkg::REG_STATUS, (32'h1 << fua_pkg::STAT_ARMED_BIT) | (32'h1 << fua_pkg::STAT_ADDRV_BIT));
        wr(fua_pkg::REG_KEY, fua_pkg::KEY_SECOND);
        rd(fua_pkg::REG_STATUS, (32'h1 << fua_pkg::STAT_UNLOCK_BIT) | (32'h1 << fua_pkg::STAT_ADDRV_BIT));
        start(1'b1);
        exp_gos++;
        exp_q.push_back(m_addr & 32'hFFFFF800);
        @(posedge clk_in);
        #1 chk(go_count, exp_gos);
        chk(last_addr, exp_q.pop_front());
        start(1'b0);
        wr(fua_pkg::REG_KEY, fua_pkg::KEY_FIRST);
        wr(fua_pkg::REG_ADDR, m_addr);
        wr(fua_pkg::REG_KEY, fua_pkg::KEY_SECOND);
        start(1'b0);
        @(posedge clk_in);
        #1 chk(go_count, exp_gos);
        @(posedge clk_in);
        rst_in <= 1'b1;
        @(posedge clk_in);
        rst_in <= 1'b0;
        rd(fua_pkg::REG_ADDR, m_addr);
        @(posedge clk_in);
        rst_in <= 1'b1; por_in <= 1'b1;
        @(posedge clk_in);
        rst_in <= 1'b0; por_in <= 1'b0;
        rd(fua_pkg::REG_ADDR, fua_pkg::ADDR_RESET);
        end_of_test();
    end

    // --------------------------------------------------------
    // watchdog
    // --------------------------------------------------------
    initial
    begin
        repeat (2000) @(posedge clk_in);
        err_count++;
        end_of_test();
    end
endmodule : tb_fua_flash_regs
`default_nettype wire
